// [src/ddrt_ctrl_end.sv]
`timescale 1ns/10ps
// Behaviour
// (RQ1) Termination high four cycles unless full write.
// (RQ2) Full-burst write holds termination six cycles.
// (RQ3) First strobe rise forty cycles after leveling.
// (RQ4) Strobe driven only twenty-five cycles after leveling.
// (RQ5) Refresh blocks activate and refresh 160 ns.
// (RQ6) Refresh on average every 7.8 or 3.9 us.
// (RQ7) Reads and termination need a locked loop.
// (RQ8) Write recovery cycles round up for power-down.
// (RQ9) Internal write starts four or two after latency.
// (RQ10) Power-down entry allowed while operations finish.
// (RQ11) After refresh, wait locked-command exit delay too.
// (RQ12) Short calibration corrects a step within 64 cycles.
// (RQ13) Slow clock fine while refresh average holds.
// (RQ14) Latency settings must both suit the clock.
// (RQ15) Pattern register returns fixed calibration bits.
// (RQ16) Pattern mode enabled idle; selector zero alternates.
// (RQ17) Pattern mode allows reads only; autoclose ignored. The code also lets mode-set commands through.
// (RQ18) Pattern bit on line zero, others copy.
module ddrt_ctrl_end (
  input wire logic clock,
  input wire logic rst,
  ddrt_link_if.ctrl link,
  input wire logic [ddrt_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData
);
  import ddrt_pkg::*;

  typedef struct packed {
    logic cmdPend;
    ddrt_cmd_t pendCmd;
    logic [BANK_W-1:0] pendBank;
    logic [ADDR_W-1:0] pendAddr;
    ddrt_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic cke;
    logic termCtrl;
    logic strobe;
    logic strobeOeN;
    logic autoRef;
    logic hot;
    logic pdReq;
    logic termReq;
    logic pulseReq;
    logic [1:0] burstMode;
    logic [3:0] readLat;
    logic [3:0] writeLat;
    logic levelMode;
    logic patEn;
    logic [(1<<BANK_W)-1:0] openBanks;
    logic [7:0] refGap;
    logic [9:0] refiCnt;
    logic [2:0] refOwed;
    logic [2:0] termCnt;
    logic [5:0] levelCnt;
    logic [5:0] pdGap;
    logic refused;
    logic [7:0] rdShift;
    logic [31:0] rdData;
  } ddrt_ctrl_t;

  ddrt_ctrl_t q;
  ddrt_ctrl_t n;
  logic refGo;
  logic refuse;
  logic hold;
  logic chop;
  logic latBad;
  logic [5:0] gap;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    n = q;
    n.cmd = CMD_NOP;
    n.strobe = 1'b0;
    n.rdData = 32'h0;
    refuse = 1'b0;
    hold = 1'b0;
    chop = 1'b0;
    gap = 6'h00;
    latBad = q.readLat < q.writeLat || q.writeLat < 4'(LAT_MIN); // [RQ14]

    if (q.pulseReq && q.levelMode &&
        q.levelCnt >= 6'(LEVEL_TO_STROBE_CYC)) begin
      n.strobe = 1'b1; // [RQ3]
      n.pulseReq = 1'b0;
    end
    if (regWr) begin
      if (regAddr == REG_COMMAND) begin
        if (q.cmdPend) begin
          n.refused = 1'b1;
        end else begin
          n.cmdPend = 1'b1;
          n.pendCmd = ddrt_cmd_t'(regWrData[CMD_KIND_LSB +: 3]);
          n.pendBank = regWrData[CMD_BANK_LSB +: BANK_W];
          n.pendAddr = regWrData[CMD_ADDR_LSB +: ADDR_W];
        end
      end else if (regAddr == REG_CONFIG) begin
        n.autoRef = regWrData[CFG_AUTO_REF];
        n.hot = regWrData[CFG_HOT];
        n.pdReq = regWrData[CFG_PD_REQ];
        n.termReq = regWrData[CFG_TERM_REQ];
      end else if (regAddr == REG_STATUS) begin
        if (regWrData[STAT_REFUSED]) begin
          n.refused = 1'b0;
        end
      end else if (regAddr == REG_LEVEL) begin
        n.pulseReq = 1'b1;
      end
    end
    if (regRd) begin
      if (regAddr == REG_COMMAND) begin
        n.rdData[CMD_KIND_LSB +: 3] = q.pendCmd;
        n.rdData[CMD_BANK_LSB +: BANK_W] = q.pendBank;
        n.rdData[CMD_ADDR_LSB +: ADDR_W] = q.pendAddr;
      end else if (regAddr == REG_CONFIG) begin
        n.rdData[CFG_AUTO_REF] = q.autoRef;
        n.rdData[CFG_HOT] = q.hot;
        n.rdData[CFG_PD_REQ] = q.pdReq;
        n.rdData[CFG_TERM_REQ] = q.termReq;
      end else if (regAddr == REG_STATUS) begin
        n.rdData[STAT_PEND] = q.cmdPend;
        n.rdData[STAT_LOCKED] = link.dllLocked;
        n.rdData[STAT_REFUSED] = q.refused;
        n.rdData[STAT_PATTERN] = q.patEn;
        n.rdData[STAT_LAT_BAD] = latBad;
        n.rdData[STAT_POWER_DOWN] = !q.cke;
        n.rdData[STAT_LEVEL] = q.levelMode;
        n.rdData[STAT_READ_LSB +: 8] = q.rdShift;
      end
    end

    if (q.refGap != '0) begin
      n.refGap = q.refGap - 1'b1;
    end
    if (q.pdGap != '0) begin
      n.pdGap = q.pdGap - 1'b1;
    end
    if (q.termCnt != '0) begin
      n.termCnt = q.termCnt - 1'b1;
    end
    if (q.levelMode && q.levelCnt < 6'(LEVEL_TO_STROBE_CYC)) begin
      n.levelCnt = q.levelCnt + 1'b1;
    end
    // Up to seven owed refreshes are counted so a late one does not lower the average.
    if (q.refiCnt == '0) begin
      n.refiCnt = q.hot ? 10'(REFI_HOT_CYC - 1) : 10'(REFI_NORMAL_CYC - 1); // [RQ6]
      if (q.autoRef && q.refOwed != 3'(REF_OWED_MAX)) begin
        n.refOwed = q.refOwed + 1'b1; // [RQ6] [RQ13]
      end
    end else begin
      n.refiCnt = q.refiCnt - 1'b1;
    end

    refGo = q.refOwed != '0 && q.cke && q.refGap == '0 && !q.patEn &&
      q.openBanks == '0; // [RQ5] [RQ17]
    if (q.cmdPend && q.cke && !refGo) begin
      case (q.pendCmd)
        CMD_READ: begin
          refuse = !link.dllLocked; // [RQ7]
        end
        CMD_ACTIVATE, CMD_REFRESH: begin
          hold = q.refGap != '0; // [RQ5]
        end
        CMD_MODE_SET: begin
          refuse = q.pendBank == MODE_REG_PATTERN &&
            q.pendAddr[PATTERN_EN_BIT] && q.openBanks != '0; // [RQ16]
        end
        default: begin
        end
      endcase
      if (q.patEn && q.pendCmd != CMD_READ && q.pendCmd != CMD_MODE_SET) begin
        refuse = 1'b1; // [RQ17]
      end
      if (refuse) begin
        n.cmdPend = 1'b0;
        n.refused = 1'b1;
      end else if (!hold) begin
        n.cmdPend = 1'b0;
        n.cmd = q.pendCmd;
        n.bank = q.pendBank;
        n.addr = q.pendAddr;
      end
    end
    if (refGo) begin
      n.cmd = CMD_REFRESH;
      n.bank = '0;
      n.addr = '0;
      n.refOwed = n.refOwed - 1'b1;
    end

    if (q.termReq && link.dllLocked && !q.termCtrl) begin
      n.termCtrl = 1'b1;
      n.termCnt = 3'(TERM_HIGH_SHORT_CYC - 1); // [RQ1] [RQ7]
    end else if (q.termCtrl && !q.termReq && q.termCnt == '0) begin
      n.termCtrl = 1'b0;
    end

    chop = chop_of(q.burstMode, n.addr);
    case (n.cmd)
      CMD_ACTIVATE: begin
        n.openBanks[n.bank] = 1'b1;
      end
      CMD_PRECHARGE: begin
        if (n.addr[AUTOCLOSE_BIT]) begin
          n.openBanks = '0;
        end else begin
          n.openBanks[n.bank] = 1'b0;
        end
      end
      CMD_REFRESH: begin
        n.refGap = 8'(REFRESH_CYCLE_CYC - 1); // [RQ5]
        gap = 6'(REF_PD_CYC - 1); // [RQ11]
      end
      CMD_READ: begin
        if (n.addr[AUTOCLOSE_BIT] && !q.patEn) begin
          n.openBanks[n.bank] = 1'b0; // [RQ17]
        end
        gap = 6'(q.readLat) + 6'(READ_TO_PD_EXTRA - 1);
      end
      CMD_WRITE: begin
        if (n.addr[AUTOCLOSE_BIT]) begin
          n.openBanks[n.bank] = 1'b0;
        end
        if (q.burstMode == BURST_FIXED_CHOP) begin
          gap = 6'(q.writeLat) + 6'(START_AFTER_LAT_FIXED_CHOP - 1);
        end else begin
          gap = 6'(q.writeLat) + 6'(START_AFTER_LAT_FULL - 1);
        end
        gap = gap + 6'(WRITE_RECOVERY_CYC); // [RQ8]
        // Termination is synchronous, so it is only raised when locked.
        if (link.dllLocked) begin
          n.termCtrl = 1'b1;
          if (!chop) begin
            n.termCnt = 3'(TERM_HIGH_LONG_CYC - 1); // [RQ2]
          end else if (n.termCnt < 3'(TERM_HIGH_SHORT_CYC - 1)) begin
            n.termCnt = 3'(TERM_HIGH_SHORT_CYC - 1); // [RQ1]
          end
        end
      end
      CMD_MODE_SET: begin
        if (n.bank == MODE_REG_BURST) begin
          n.burstMode = n.addr[BURST_MODE_LSB +: 2];
          n.readLat = n.addr[READ_LAT_LSB +: 4];
        end else if (n.bank == MODE_REG_LOOP) begin
          n.levelMode = n.addr[LEVEL_MODE_BIT];
          n.levelCnt = 6'h00;
        end else if (n.bank == MODE_REG_WRITE) begin
          n.writeLat = n.addr[WRITE_LAT_LSB +: 4];
        end else if (n.bank == MODE_REG_PATTERN) begin
          n.patEn = n.addr[PATTERN_EN_BIT]; // [RQ16]
        end
      end
      default: begin
      end
    endcase
    if (n.pdGap < gap) begin
      n.pdGap = gap;
    end

    if (!q.cke) begin
      if (!q.pdReq || q.refOwed != '0 || q.cmdPend) begin
        n.cke = 1'b1;
      end
    end else if (q.pdReq && !q.cmdPend && q.refOwed == '0 &&
                 q.pdGap == '0 && !q.patEn && n.cmd == CMD_NOP) begin
      n.cke = 1'b0; // [RQ8] [RQ11]
    end

    n.strobeOeN = !(q.levelMode &&
      q.levelCnt >= 6'(LEVEL_TO_DRIVE_CYC)); // [RQ4]

    if (!link.dqOeN) begin
      n.rdShift = {link.dq[0], q.rdShift[7:1]}; // [RQ18]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{cmd: CMD_NOP, pendCmd: CMD_NOP, cke: 1'b1, strobeOeN: 1'b1,
             readLat: READ_LAT_RESET, writeLat: WRITE_LAT_RESET,
             refiCnt: 10'(REFI_NORMAL_CYC - 1), default: '0};
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign link.cke = q.cke;
  assign link.cmd = q.cmd;
  assign link.bank = q.bank;
  assign link.addr = q.addr;
  assign link.termCtrl = q.termCtrl;
  assign link.strobe = q.strobe;
  assign link.strobeOeN = q.strobeOeN;
  assign regRdData = q.rdData;
endmodule

// [src/ddrt_pkg.sv]
package ddrt_pkg;
  localparam int CLOCK_PERIOD_PS = 10000;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int DQ_W = 8;
  localparam int REG_ADDR_W = 8;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_WRITE,
    CMD_READ,
    CMD_MODE_SET,
    CMD_SHORT_CAL
  } ddrt_cmd_t;

  // Timing figures in their own unit, then the cycle counts at 100 MHz.
  localparam int TERM_HIGH_SHORT_CYC = 4;
  localparam int TERM_HIGH_LONG_CYC = 6;
  localparam int LEVEL_TO_STROBE_CYC = 40;
  localparam int LEVEL_TO_DRIVE_CYC = 25;
  localparam int REFRESH_CYCLE_NS = 160;
  localparam int REFRESH_CYCLE_CYC =
    (REFRESH_CYCLE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int REFI_NORMAL_NS = 7800;
  localparam int REFI_HOT_NS = 3900;
  localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS * 1000 / CLOCK_PERIOD_PS;
  localparam int REFI_HOT_CYC = REFI_HOT_NS * 1000 / CLOCK_PERIOD_PS;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WRITE_RECOVERY_CYC =
    (WRITE_RECOVERY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int START_AFTER_LAT_FULL = 4;
  localparam int START_AFTER_LAT_FIXED_CHOP = 2;
  localparam int READ_TO_PD_EXTRA = 5;
  localparam int REF_TO_PD_CYC = 1;
  localparam int EXIT_LOCKED_NS = 24;
  localparam int EXIT_LOCKED_MIN_CYC = 10;
  localparam int EXIT_LOCKED_NS_CYC =
    (EXIT_LOCKED_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int EXIT_LOCKED_CYC = EXIT_LOCKED_NS_CYC > EXIT_LOCKED_MIN_CYC ?
    EXIT_LOCKED_NS_CYC : EXIT_LOCKED_MIN_CYC;
  localparam int REF_PD_CYC = EXIT_LOCKED_CYC > REF_TO_PD_CYC ?
    EXIT_LOCKED_CYC : REF_TO_PD_CYC;
  localparam int SHORT_CAL_CYC = 64;
  localparam int ROW_OP_CYC = 4;
  localparam int DLL_LOCK_CYC = 512;
  localparam int LAT_MIN = 5;
  localparam int REF_OWED_MAX = 7;

  // Mode register selection on the bank lines and field positions.
  localparam logic [BANK_W-1:0] MODE_REG_BURST = 3'h0;
  localparam logic [BANK_W-1:0] MODE_REG_LOOP = 3'h1;
  localparam logic [BANK_W-1:0] MODE_REG_WRITE = 3'h2;
  localparam logic [BANK_W-1:0] MODE_REG_PATTERN = 3'h3;
  localparam int BURST_MODE_LSB = 0;
  localparam int READ_LAT_LSB = 4;
  localparam int LOOP_OFF_BIT = 0;
  localparam int LEVEL_MODE_BIT = 7;
  localparam int WRITE_LAT_LSB = 3;
  localparam int PATTERN_EN_BIT = 2;
  localparam int PATTERN_SEL_LSB = 0;
  localparam logic [1:0] PATTERN_SEL_CALIB = 2'h0;
  localparam logic [1:0] BURST_FIXED_FULL = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
  localparam int AUTOCLOSE_BIT = 10;
  localparam int CHOP_N_BIT = 12;
  localparam int NIBBLE_BIT = 2;
  localparam logic [3:0] READ_LAT_RESET = 4'h6;
  localparam logic [3:0] WRITE_LAT_RESET = 4'h5;
  localparam logic [7:0] CAL_CODE_RESET = 8'h80;

  // Controller register map and field positions.
  localparam logic [REG_ADDR_W-1:0] REG_COMMAND = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_CONFIG = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_LEVEL = 8'h0c;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CFG_AUTO_REF = 0;
  localparam int CFG_HOT = 1;
  localparam int CFG_PD_REQ = 2;
  localparam int CFG_TERM_REQ = 3;
  localparam int STAT_PEND = 0;
  localparam int STAT_LOCKED = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_PATTERN = 3;
  localparam int STAT_LAT_BAD = 4;
  localparam int STAT_POWER_DOWN = 5;
  localparam int STAT_LEVEL = 6;
  localparam int STAT_READ_LSB = 8;

  function automatic logic chop_of(input logic [1:0] mode,
                                   input logic [ADDR_W-1:0] a);
    return mode == BURST_FIXED_CHOP ||
      (mode == BURST_ON_THE_FLY && !a[CHOP_N_BIT]);
  endfunction
endpackage

// [src/ddrt_link_if.sv]
`timescale 1ns/10ps
interface ddrt_link_if;
  import ddrt_pkg::*;
  logic cke;
  ddrt_cmd_t cmd;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic termCtrl;
  logic strobe;
  logic strobeOeN;
  logic [DQ_W-1:0] dq;
  logic dqOeN;
  logic dllLocked;

  modport dram (
    input cke, cmd, bank, addr, termCtrl, strobe, strobeOeN,
    output dq, dqOeN, dllLocked
  );
  modport ctrl (
    output cke, cmd, bank, addr, termCtrl, strobe, strobeOeN,
    input dq, dqOeN, dllLocked
  );
endinterface

// [src/ddrt_dram_end.sv]
`timescale 1ns/10ps
module ddrt_dram_end #(
  parameter int LOCK_CYC = ddrt_pkg::DLL_LOCK_CYC,
  parameter bit COPY_PATTERN = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  ddrt_link_if.dram link,
  input wire logic [ddrt_pkg::DQ_W-1:0] arrayData,
  input wire logic [7:0] calTarget,
  output logic writeStart,
  output logic writeChop,
  output logic lowPower,
  output logic calBusy,
  output logic [7:0] calCode
);
  import ddrt_pkg::*;

  localparam int LCW = $clog2(LOCK_CYC + 1);

  typedef struct packed {
    logic [1:0] burstMode;
    logic [3:0] readLat;
    logic [3:0] writeLat;
    logic levelMode;
    logic loopOff;
    logic patEn;
    logic [1:0] patSel;
    logic [LCW-1:0] lockCnt;
    logic locked;
    logic wrPend;
    logic [4:0] wrCnt;
    logic writeStart;
    logic writeChop;
    logic [7:0] busyCnt;
    logic lowPower;
    logic [6:0] calCnt;
    logic calBusy;
    logic [7:0] calCode;
    logic rdPend;
    logic [3:0] rdCnt;
    logic rdChop;
    logic rdPat;
    logic [3:0] beatsLeft;
    logic [2:0] beatIdx;
    logic [DQ_W-1:0] dq;
    logic dqOeN;
  } ddrt_dram_t;

  ddrt_dram_t q;
  ddrt_dram_t n;

  // Pattern beats with selector zero carry the beat index parity on line zero.
  function automatic logic [DQ_W-1:0] beat_of(input ddrt_dram_t s,
                                              input logic [2:0] idx,
                                              input logic [DQ_W-1:0] arr);
    logic b;
    b = (s.patSel == PATTERN_SEL_CALIB) & idx[0]; // [RQ16]
    if (!s.rdPat) begin
      return arr;
    end
    return COPY_PATTERN ? {DQ_W{b}} : {{(DQ_W-1){1'b0}}, b}; // [RQ15] [RQ18]
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    n = q;
    n.writeStart = 1'b0;
    n.dqOeN = 1'b1;
    n.dq = '0;
    if (!q.loopOff && !q.locked) begin
      if (q.lockCnt == LCW'(LOCK_CYC - 1)) begin
        n.locked = 1'b1;
      end else begin
        n.lockCnt = q.lockCnt + 1'b1;
      end
    end
    if (q.busyCnt != '0) begin
      n.busyCnt = q.busyCnt - 1'b1;
    end
    // One code step is the least correction; the step lands inside the window.
    if (q.calBusy) begin
      if (q.calCnt == 7'(SHORT_CAL_CYC - 1)) begin
        n.calBusy = 1'b0;
        if (q.calCode < calTarget) begin
          n.calCode = q.calCode + 1'b1; // [RQ12]
        end else if (q.calCode > calTarget) begin
          n.calCode = q.calCode - 1'b1; // [RQ12]
        end
      end else begin
        n.calCnt = q.calCnt + 1'b1;
      end
    end
    if (q.wrPend) begin
      if (q.wrCnt == '0) begin
        n.wrPend = 1'b0;
        n.writeStart = 1'b1; // [RQ9]
      end else begin
        n.wrCnt = q.wrCnt - 1'b1;
      end
    end
    if (q.rdPend) begin
      if (q.rdCnt == '0) begin
        n.rdPend = 1'b0;
        n.dqOeN = 1'b0;
        n.dq = beat_of(q, q.beatIdx, arrayData);
        n.beatIdx = q.beatIdx + 1'b1;
        n.beatsLeft = q.rdChop ? 4'h3 : 4'h7;
      end else begin
        n.rdCnt = q.rdCnt - 1'b1;
      end
    end else if (q.beatsLeft != '0) begin
      n.dqOeN = 1'b0;
      n.dq = beat_of(q, q.beatIdx, arrayData);
      n.beatIdx = q.beatIdx + 1'b1;
      n.beatsLeft = q.beatsLeft - 1'b1;
    end
    if (link.cke) begin
      n.lowPower = 1'b0;
      case (link.cmd)
        CMD_ACTIVATE, CMD_PRECHARGE: begin
          n.busyCnt = 8'(ROW_OP_CYC);
        end
        CMD_REFRESH: begin
          n.busyCnt = 8'(REFRESH_CYCLE_CYC);
        end
        CMD_WRITE: begin
          n.wrPend = 1'b1;
          n.writeChop = chop_of(q.burstMode, link.addr);
          if (q.burstMode == BURST_FIXED_CHOP) begin
            n.wrCnt = 5'(q.writeLat) + 5'(START_AFTER_LAT_FIXED_CHOP - 1); // [RQ9]
          end else begin
            n.wrCnt = 5'(q.writeLat) + 5'(START_AFTER_LAT_FULL - 1); // [RQ9]
          end
          if (link.addr[AUTOCLOSE_BIT]) begin
            n.busyCnt = 8'(ROW_OP_CYC);
          end
        end
        CMD_READ: begin
          if (q.locked && !q.rdPend && q.beatsLeft == '0) begin
            n.rdPend = 1'b1;
            n.rdCnt = q.readLat - 1'b1;
            n.rdChop = chop_of(q.burstMode, link.addr);
            n.rdPat = q.patEn;
            n.beatIdx = {link.addr[NIBBLE_BIT], 2'b00};
            // Pattern reads drop the close request entirely.
            if (link.addr[AUTOCLOSE_BIT] && !q.patEn) begin
              n.busyCnt = 8'(ROW_OP_CYC); // [RQ17]
            end
          end
        end
        CMD_MODE_SET: begin
          if (link.bank == MODE_REG_BURST) begin
            n.burstMode = link.addr[BURST_MODE_LSB +: 2];
            n.readLat = link.addr[READ_LAT_LSB +: 4];
          end else if (link.bank == MODE_REG_LOOP) begin
            n.levelMode = link.addr[LEVEL_MODE_BIT];
            n.loopOff = link.addr[LOOP_OFF_BIT];
            if (link.addr[LOOP_OFF_BIT] || q.loopOff) begin
              n.locked = 1'b0;
              n.lockCnt = '0;
            end
          end else if (link.bank == MODE_REG_WRITE) begin
            n.writeLat = link.addr[WRITE_LAT_LSB +: 4];
          end else if (link.bank == MODE_REG_PATTERN) begin
            n.patEn = link.addr[PATTERN_EN_BIT]; // [RQ16]
            n.patSel = link.addr[PATTERN_SEL_LSB +: 2];
          end
        end
        CMD_SHORT_CAL: begin
          n.calBusy = 1'b1;
          n.calCnt = '0;
        end
        default: begin
        end
      endcase
    end else begin
      // Clock enable may drop mid-operation; low power waits for busyCnt and calibration to finish, not for a read burst.
      n.lowPower = q.busyCnt == '0 && !q.calBusy; // [RQ10]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{readLat: READ_LAT_RESET, writeLat: WRITE_LAT_RESET,
             calCode: CAL_CODE_RESET, dqOeN: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign link.dq = q.dq;
  assign link.dqOeN = q.dqOeN;
  assign link.dllLocked = q.locked;
  assign writeStart = q.writeStart;
  assign writeChop = q.writeChop;
  assign lowPower = q.lowPower;
  assign calBusy = q.calBusy;
  assign calCode = q.calCode;
endmodule

// [verif/ddrt_link_assertions.sv]
`timescale 1ns/10ps
module ddrt_link_checker (
  input logic clock,
  input logic rst,
  input logic cke,
  input ddrt_pkg::ddrt_cmd_t cmd,
  input logic [ddrt_pkg::BANK_W-1:0] bank,
  input logic [ddrt_pkg::ADDR_W-1:0] addr,
  input logic termCtrl,
  input logic strobe,
  input logic strobeOeN,
  input logic [ddrt_pkg::DQ_W-1:0] dq,
  input logic dqOeN,
  input logic dllLocked
);
  import ddrt_pkg::*;
  logic [5:0] lvl_q;
  logic [4:0] ref_q;
  logic pat_q;
  logic chop_q;
  logic ms;
  assign ms = cmd == CMD_MODE_SET;
  // Saturating ages cover gaps too long to repeat.
  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_q <= 6'h3f;
      ref_q <= 5'h1f;
      pat_q <= 1'b0;
      chop_q <= 1'b0;
    end else begin
      if (ms && bank == MODE_REG_LOOP && addr[LEVEL_MODE_BIT])
        lvl_q <= 6'h0;
      else if (lvl_q != 6'h3f)
        lvl_q <= lvl_q + 6'h1;
      if (cmd == CMD_REFRESH)
        ref_q <= 5'h0;
      else if (ref_q != 5'h1f)
        ref_q <= ref_q + 5'h1;
      if (ms && bank == MODE_REG_PATTERN)
        pat_q <= addr[PATTERN_EN_BIT];
      if (ms && bank == MODE_REG_BURST)
        chop_q <= addr[1:0] == BURST_FIXED_CHOP;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_term_short: assert property ($rose(termCtrl) |->
    termCtrl[*4]) else $error("termination high too briefly");
  a_term_long: assert property (
    cmd == CMD_WRITE && dllLocked && addr[CHOP_N_BIT] && !chop_q
    |=> termCtrl[*5]) else $error("termination short on full write");
  a_strobe_first: assert property (strobe |-> lvl_q >= 40)
    else $error("strobe too soon after leveling");
  a_strobe_drive: assert property (!strobeOeN |-> lvl_q >= 25)
    else $error("strobe driven too soon");
  a_refresh_gap: assert property (
    cmd inside {CMD_ACTIVATE, CMD_REFRESH} |-> ref_q >= 15)
    else $error("command too soon after refresh");
  a_read_locked: assert property (cmd == CMD_READ |-> dllLocked)
    else $error("read while unlocked");
  a_read_burst: assert property (
    cmd == CMD_READ && dllLocked && cke && dqOeN |-> ##7 (!dqOeN)[*8])
    else $error("read burst misplaced");
  a_pattern_start: assert property (
    !dqOeN && $past(dqOeN) && pat_q |-> !dq[0])
    else $error("pattern starts wrong");
  a_pattern_alt: assert property (
    !dqOeN && !$past(dqOeN) && pat_q |-> dq[0] != $past(dq[0]))
    else $error("pattern does not alternate");
  a_pattern_only: assert property (
    pat_q |-> cmd inside {CMD_NOP, CMD_READ, CMD_MODE_SET})
    else $error("bad command in pattern mode");
  a_lines_copy: assert property (
    !dqOeN && pat_q |-> dq[7:1] == {7{dq[0]}} || dq[7:1] == 7'h0)
    else $error("upper lines wrong");
  a_pd_gap: assert property ($fell(cke) |-> ref_q >= 9)
    else $error("power-down too soon after refresh");
  c_refresh: cover property (cmd == CMD_REFRESH);
  c_pattern: cover property (!dqOeN && pat_q);
  c_strobe: cover property (strobe);
  c_pd: cover property ($fell(cke));
endmodule

// [verif/ddr3_command_timing_rules_tb_top.sv]
`timescale 1ns/10ps
module ddr3_command_timing_rules_tb_top;
  import ddrt_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [REG_ADDR_W-1:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdWas = 1'b0;
  logic [31:0] regRdData;
  logic [DQ_W-1:0] arrayData = 8'h00;
  logic [7:0] calTarget = 8'h80;
  logic writeStart, writeChop, lowPower, calBusy;
  logic [7:0] calCode;
  logic [31:0] rdQ[$], mkQ[$], wsQ[$];
  int cyc = 0, wsOff = 4, refN = 0, failures = 0, tests_run = 0, n;
  ddrt_link_if lnk();
  always #5 clock = ~clock;
  ddrt_dram_end #(.LOCK_CYC(16)) ddrt_dram_end_i (.clock, .rst,
    .link(lnk), .arrayData, .calTarget, .writeStart, .writeChop,
    .lowPower, .calBusy, .calCode);
  ddrt_ctrl_end ddrt_ctrl_end_i (.clock, .rst, .link(lnk), .regAddr,
    .regWrData, .regWr, .regRd, .regRdData);
  ddrt_link_checker ddrt_link_checker_i (.clock, .rst, .cke(lnk.cke),
    .cmd(lnk.cmd), .bank(lnk.bank), .addr(lnk.addr),
    .termCtrl(lnk.termCtrl), .strobe(lnk.strobe),
    .strobeOeN(lnk.strobeOeN), .dq(lnk.dq), .dqOeN(lnk.dqOeN),
    .dllLocked(lnk.dllLocked));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; s !== v && i < lim; i++) @(negedge clock);
    if (s !== v) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(e & m);
    mkQ.push_back(m);
    @(posedge clock);
    regRd <= 1'b0;
  endtask
  task automatic issue(ddrt_cmd_t k, logic [2:0] b, logic [13:0] a);
    wr(REG_COMMAND, {2'h0, a, 9'h0, b, 1'b0, k});
    repeat (4) @(posedge clock);
  endtask
  ////////////////////////////////////////
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rdWas <= regRd;
    arrayData <= 8'($urandom);
  end
  always @(negedge clock) begin
    if (rdWas) chk(rdQ.pop_front(), regRdData & mkQ.pop_front());
    if (lnk.cmd == CMD_WRITE)
      wsQ.push_back({wsOff == 2, 31'(cyc + 1 + WRITE_LAT_RESET + wsOff)});
    if (lnk.cmd == CMD_REFRESH) refN++;
    if (writeStart) chk(wsQ.pop_front(), {writeChop, 31'(cyc)});
  end
  initial begin
    n = $urandom(32'hf8f8f5fa);
    calTarget <= 8'h81 + 8'($urandom % 64);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // Lock needs 16 cycles, so this read is refused on purpose.
    issue(CMD_READ, 3'h0, 14'h0);
    rd(REG_STATUS, 32'h4, 32'h6);
    rd(8'h10, 32'h0, 32'hffffffff);
    wr(REG_STATUS, 32'h4);
    wr(REG_CONFIG, 32'h8);
    repeat (10) @(posedge clock);
    rd(REG_STATUS, 32'h2, 32'h6);
    rd(REG_CONFIG, 32'h8, 32'hf);
    wr(REG_CONFIG, 32'h0);
    $display("test registers done");
    for (int m = 2; m >= 0; m--) begin
      wsOff = m == 2 ? START_AFTER_LAT_FIXED_CHOP : START_AFTER_LAT_FULL;
      issue(CMD_MODE_SET, MODE_REG_BURST, 14'h60 | 14'(m));
      issue(CMD_WRITE, 3'h0, 14'h1000);
      repeat (16) @(posedge clock);
    end
    chk(0, wsQ.size());
    $display("test write start done");
    issue(CMD_REFRESH, 3'h0, 14'h0);
    issue(CMD_REFRESH, 3'h0, 14'h0);
    repeat (20) @(posedge clock);
    refN = 0;
    wr(REG_CONFIG, 32'h1);
    repeat (1700) @(posedge clock);
    chk(1, refN >= 2);
    refN = 0;
    wr(REG_CONFIG, 32'h3);
    repeat (1700) @(posedge clock);
    chk(1, refN >= 3);
    wr(REG_CONFIG, 32'h0);
    $display("test refresh done");
    issue(CMD_MODE_SET, MODE_REG_PATTERN, 14'h4);
    issue(CMD_READ, 3'h5, 14'h0400);
    repeat (16) @(posedge clock);
    rd(REG_STATUS, 32'haa08, 32'hff08);
    issue(CMD_WRITE, 3'h0, 14'h0);
    rd(REG_STATUS, 32'h4, 32'h4);
    wr(REG_STATUS, 32'h4);
    issue(CMD_MODE_SET, MODE_REG_PATTERN, 14'h0);
    $display("test pattern done");
    issue(CMD_MODE_SET, MODE_REG_LOOP, 14'h80);
    wr(REG_LEVEL, 32'h1);
    wt(lnk.strobe, 1'b1, 100);
    rd(REG_STATUS, 32'h40, 32'h40);
    issue(CMD_MODE_SET, MODE_REG_LOOP, 14'h0);
    $display("test leveling done");
    wr(REG_COMMAND, 32'(CMD_SHORT_CAL));
    wt(calBusy, 1'b1, 10);
    for (n = 1; calBusy === 1'b1 && n < 100; n++) @(negedge clock);
    chk(64, n - 1);
    chk(8'h81, calCode);
    $display("test calibration done");
    wr(REG_COMMAND, 32'(CMD_ACTIVATE));
    wr(REG_CONFIG, 32'h4);
    wt(lnk.cke, 1'b0, 40);
    chk(0, lowPower);
    wt(lowPower, 1'b1, 20);
    rd(REG_STATUS, 32'h20, 32'h20);
    wr(REG_CONFIG, 32'h0);
    wt(lnk.cke, 1'b1, 10);
    wt(lowPower, 1'b0, 10);
    $display("test power-down done");
    close_out();
  end
endmodule
